// file: src/ftd_timer.sv
// fast 8-bit timer with three compares and two complementary pwm outputs
// assumes avalon-mm master on the system clock and a fast clock tick pulse
//
// What this block does
// R1 - sync mode counts system clock, async mode fast clock when enabled.
// R2 - prescaler offers stop and division by 1 up to 16384.
// R3 - writing the prescaler reset bit clears the prescaler state.
// R4 - fast clock base is 64 MHz, or 32 MHz in low speed.
// R5 - control and compare registers read back new value at once.
// R6 - writes pass sync stages; count and flags read back delayed.
// R7 - clock source keeps system clock below a third of fast clock; here fast ticks are pulses on the faster 125 MHz system clock.
// R8 - software starts pll, waits, polls lock, then enables async mode.
// R9 - counter compared to a, b and top; top is clear value.
// R10 - a and b drive pins and set match flags in both modes.
// R11 - normal mode: overflow flag on wrap from ff to 00.
// R12 - pwm mode: overflow on return to zero, after sync delay.
// R13 - normal mode leaves both inverted outputs disconnected.
// R14 - pwm counts zero to top, restarts; true and inverted pins.
// R15 - complementary outputs switch together, zero dead time.
// R16 - two-bit output mode selects pwm pin behaviour per channel.
// R17 - pwm compare writes buffered, transferred when counter reaches top.
// R18 - reads of a or b return the buffered, latest value.
// R19 - compare at zero or top holds output constant by mode.
// R20 - constant levels per mode: 01, 10, 11 as tabulated.
// R21 - clear-on-top resets counter after top match, else counts on.
// R22 - pwm period is top plus one counter ticks.
// R23 - flags clear on writing one or on interrupt service.
// R24 - stopped prescaler holds count and raises no events.
module ftd_timer
  import ftd_pkg::*;
(
  input wire logic i_clk_sys, // system clock, 125 MHz
  input wire logic i_reset, // synchronous reset, high
  input wire logic [5:0] i_avs_address, // byte address
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] i_avs_writedata, // write data
  output logic [31:0] o_avs_readdata, // read data
  output logic o_avs_waitrequest, // high until answered
  input wire logic i_pck_tick, // one pulse per fast clock edge
  input wire logic i_pll_lock, // pll lock level
  input wire logic [2:0] i_irq_ack, // interrupt serviced, per flag
  output logic [2:0] o_irq_req, // flag and mask
  output logic o_compare_output_a, // channel a true
  output logic o_compare_output_a_oe, // drive enable
  output logic o_compare_output_a_n, // channel a inverted
  output logic o_compare_output_a_n_oe, // drive enable
  output logic o_compare_output_b, // channel b true
  output logic o_compare_output_b_oe, // drive enable
  output logic o_compare_output_b_n, // channel b inverted
  output logic o_compare_output_b_n_oe // drive enable
);

  ftd_psc_if psc ();

  logic wait_q;
  logic [31:0] rdata_q;
  logic [7:0] rd_byte;
  logic rd_take;
  logic wr_en;
  logic [7:0] tctl_q;
  logic [1:0] modeb_q;
  logic [7:0] cmpa_buf_q;
  logic [7:0] cmpb_buf_q;
  logic [7:0] top_q;
  logic ace_q;
  logic [2:0] imask_q;
  logic [2:0] flags_q;
  logic [2:0] flags_d;
  logic [2:0] flag_clr;
  logic psr_q;
  ftd_ctl_s ctl_now;
  ftd_ctl_s sync1_q;
  ftd_ctl_s c_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_rd_q;
  logic [7:0] act_a_q;
  logic [7:0] act_b_q;
  logic tick;
  logic top_hit;
  logic clr_top;
  logic [2:0] evt;
  logic [2:0] evt_q;
  logic lvl_a;
  logic lvl_b;

  // pwm level: constant cases first, then match, then count zero
  function automatic logic pwm_level(input ftd_outmode_e m,
    input logic [7:0] cmp, input logic [7:0] top, input logic [7:0] cnt,
    input logic cur);
    logic hi_on_match;
    hi_on_match = (m == FTD_OUT_SET_CLR);
    if (cmp == 8'h00) begin // R19 R20
      pwm_level = hi_on_match;
    end else if (cmp == top) begin // R19 R20
      pwm_level = !hi_on_match;
    end else if (cnt == cmp) begin // R16
      pwm_level = hi_on_match;
    end else if (cnt == 8'h00) begin // R16
      pwm_level = !hi_on_match;
    end else begin
      pwm_level = cur;
    end
  endfunction

  // normal mode: toggle, clear or set on a match tick
  function automatic logic nrm_level(input ftd_outmode_e m,
    input logic hit, input logic cur);
    nrm_level = cur;
    if (hit) begin
      unique case (m)
        FTD_OUT_OFF: nrm_level = cur;
        FTD_OUT_CLR_SET: nrm_level = !cur;
        FTD_OUT_CLR_ONLY: nrm_level = 1'b0;
        FTD_OUT_SET_CLR: nrm_level = 1'b1;
      endcase
    end
  endfunction

  // bus handshake: one wait cycle, then answer for one cycle
  assign rd_take = i_avs_read && wait_q;
  assign wr_en = i_avs_write && !wait_q;
  assign o_avs_waitrequest = wait_q;
  assign o_avs_readdata = rdata_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !((i_avs_read || i_avs_write) && wait_q);
    end
  end

  // read mux; count and flags are the delayed copies
  always_comb begin
    rd_byte = 8'h00;
    unique case (i_avs_address)
      ADDR_TCTL: rd_byte = tctl_q; // R5
      ADDR_GTC: rd_byte = {2'h0, modeb_q, 4'h0};
      ADDR_CNT: rd_byte = cnt_rd_q; // R6
      ADDR_CMPA: rd_byte = cmpa_buf_q; // R18
      ADDR_CMPB: rd_byte = cmpb_buf_q; // R18
      ADDR_TOP: rd_byte = top_q; // R5
      ADDR_FLAG: rd_byte = {5'h00, flags_q}; // R6
      ADDR_PLL: rd_byte = {5'h00, ace_q, 1'b0, i_pll_lock};
      ADDR_MASK: rd_byte = {5'h00, imask_q};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // software registers, visible to reads straight after the write
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      tctl_q <= RST_TCTL;
      modeb_q <= RST_MODEB;
      cmpa_buf_q <= RST_CMP;
      cmpb_buf_q <= RST_CMP;
      top_q <= RST_TOP;
      ace_q <= 1'b0;
      imask_q <= 3'h0;
    end else if (wr_en) begin // R5
      unique case (i_avs_address)
        ADDR_TCTL: tctl_q <= i_avs_writedata[7:0];
        ADDR_GTC: modeb_q <= i_avs_writedata[GTC_MODEB_LSB +: 2];
        ADDR_CMPA: cmpa_buf_q <= i_avs_writedata[7:0]; // R17
        ADDR_CMPB: cmpb_buf_q <= i_avs_writedata[7:0]; // R17
        ADDR_TOP: top_q <= i_avs_writedata[7:0];
        ADDR_PLL: ace_q <= i_avs_writedata[PLL_ACE_BIT]; // R1
        ADDR_MASK: imask_q <= i_avs_writedata[2:0];
        default: ;
      endcase
    end
  end

  // prescaler reset strobe, reads as zero
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      psr_q <= 1'b0;
    end else begin
      psr_q <= wr_en && (i_avs_address == ADDR_GTC) // R3
        && i_avs_writedata[GTC_PSR_BIT];
    end
  end

  // input synchronisation: two stages before the counter sees a value
  assign ctl_now = '{ctc: tctl_q[TCTL_CTC_BIT], pwm: tctl_q[TCTL_PWM_BIT],
    mode_a: tctl_q[TCTL_MODE_LSB +: 2], psel: tctl_q[TCTL_PSEL_LSB +: 4],
    mode_b: modeb_q, cmp_a: cmpa_buf_q, cmp_b: cmpb_buf_q, top: top_q,
    async_en: ace_q};

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      sync1_q <= '0;
      c_q <= '0;
    end else begin
      sync1_q <= ctl_now; // R6
      c_q <= sync1_q; // R6
    end
  end

  // base tick: every cycle, or each fast clock pulse (64 or 32 MHz)
  assign psc.base_tick = c_q.async_en ? i_pck_tick : 1'b1; // R1 R4
  assign psc.clear = psr_q; // R3
  assign psc.select = c_q.psel; // R2
  assign tick = psc.tick; // R24

  ftd_prescaler #(.DIV_W(PSC_W)) u_psc (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .p(psc)
  );

  // counter: clear after top match in clear-on-top or pwm mode
  assign top_hit = (cnt_q == c_q.top); // R9
  assign clr_top = (c_q.ctc || c_q.pwm) && top_hit; // R21 R14 R22

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cnt_q <= 8'h00;
    end else if (tick) begin // R24
      cnt_q <= clr_top ? 8'h00 : cnt_q + 8'h01; // R21
    end
  end

  // active compares: buffered in pwm mode, loaded at top
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      act_a_q <= RST_CMP;
      act_b_q <= RST_CMP;
    end else if (!c_q.pwm || (tick && top_hit)) begin // R17
      act_a_q <= c_q.cmp_a;
      act_b_q <= c_q.cmp_b;
    end
  end

  // events only on ticks; one stage of delay before the flags
  assign evt[FLAG_A_BIT] = tick && (cnt_q == act_a_q); // R9 R10
  assign evt[FLAG_B_BIT] = tick && (cnt_q == act_b_q); // R9 R10
  assign evt[FLAG_OVF_BIT] = tick // R11 R12
    && ((cnt_q == CNT_MAX) || (c_q.pwm && clr_top));

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      evt_q <= 3'h0;
      cnt_rd_q <= 8'h00;
    end else begin
      evt_q <= evt; // R12
      cnt_rd_q <= cnt_q; // R6
    end
  end

  // flags: write one or service clears, a new event wins
  assign flag_clr = i_irq_ack // R23
    | ((wr_en && i_avs_address == ADDR_FLAG) ? i_avs_writedata[2:0] : 3'h0);
  assign flags_d = (flags_q & ~flag_clr) | evt_q; // R23

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      flags_q <= RST_FLAGS;
      o_irq_req <= 3'h0;
    end else begin
      flags_q <= flags_d;
      o_irq_req <= flags_d & imask_q; // R10
    end
  end

  // compare output levels per mode
  assign lvl_a = c_q.pwm
    ? pwm_level(ftd_outmode_e'(c_q.mode_a), act_a_q, c_q.top, cnt_q,
      o_compare_output_a)
    : nrm_level(ftd_outmode_e'(c_q.mode_a), evt[FLAG_A_BIT],
      o_compare_output_a);
  assign lvl_b = c_q.pwm
    ? pwm_level(ftd_outmode_e'(c_q.mode_b), act_b_q, c_q.top, cnt_q,
      o_compare_output_b)
    : nrm_level(ftd_outmode_e'(c_q.mode_b), evt[FLAG_B_BIT],
      o_compare_output_b);

  // output pins: inverted copy on the same edge, no dead time
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_compare_output_a <= 1'b0;
      o_compare_output_a_n <= 1'b1;
      o_compare_output_b <= 1'b0;
      o_compare_output_b_n <= 1'b1;
    end else begin
      o_compare_output_a <= lvl_a; // R10 R16
      o_compare_output_a_n <= !lvl_a; // R15
      o_compare_output_b <= lvl_b; // R10 R16
      o_compare_output_b_n <= !lvl_b; // R15
    end
  end

  // output enables: inverted pins only in pwm mode 01
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_compare_output_a_oe <= 1'b0;
      o_compare_output_a_n_oe <= 1'b0;
      o_compare_output_b_oe <= 1'b0;
      o_compare_output_b_n_oe <= 1'b0;
    end else begin
      o_compare_output_a_oe <= (c_q.mode_a != 2'h0); // R16
      o_compare_output_b_oe <= (c_q.mode_b != 2'h0); // R16
      o_compare_output_a_n_oe <= c_q.pwm // R13 R14
        && (c_q.mode_a == 2'h1);
      o_compare_output_b_n_oe <= c_q.pwm // R13 R14
        && (c_q.mode_b == 2'h1);
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  sequence s_bus_new;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_top_wrap;
    tick && c_q.pwm && top_hit;
  endsequence

  bus_answer_a: assert property (s_bus_new |=>
    !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  top_readback_a: assert property ( // R5
    (wr_en && i_avs_address == ADDR_TOP) |=>
    top_q == $past(i_avs_writedata[7:0]))
    else $error("top value not stored on write");
  sync_delay_a: assert property (c_q.top == $past(top_q, 2)) // R6
    else $error("top value not two stages late");
  stop_hold_a: assert property ((c_q.psel == 4'h0) |=> $stable(cnt_q)) // R24
    else $error("counter moved while stopped");
  top_clear_a: assert property ((tick && clr_top) |=> cnt_q == 8'h00) // R21
    else $error("counter not cleared after top");
  ovf_flag_a: assert property ( // R12
    (s_top_wrap and (flag_clr == 3'h0)) |-> ##2 flags_q[FLAG_OVF_BIT])
    else $error("overflow flag not set after top");
  buf_xfer_a: assert property (s_top_wrap |=> // R17
    act_a_q == $past(c_q.cmp_a))
    else $error("buffered compare a not loaded at top");
  inv_off_a: assert property (!c_q.pwm |=> !o_compare_output_a_n_oe) // R13
    else $error("inverted a driven in normal mode");
  const_lvl_a: assert property ( // R20
    (c_q.pwm && act_a_q == 8'h00 && c_q.mode_a == 2'h3)
    |=> o_compare_output_a)
    else $error("mode 11 at zero compare not high");
  compl_pair_a: assert property ( // R15
    o_compare_output_a_n_oe |-> o_compare_output_a_n != o_compare_output_a)
    else $error("inverted a not complement");

endmodule // ftd_timer

// file: src/ftd_pkg.sv
// constants, field layout and types shared by the fast dual pwm timer
// assumes one 125 MHz system clock and a byte-addressed avalon slave
package ftd_pkg;

  // register byte offsets, one 32-bit word each
  localparam logic [5:0] ADDR_TCTL = 6'h00; // timer_control
  localparam logic [5:0] ADDR_GTC = 6'h04; // general_timer_control
  localparam logic [5:0] ADDR_CNT = 6'h08; // timer_count, read only
  localparam logic [5:0] ADDR_CMPA = 6'h0C; // compare_value_a
  localparam logic [5:0] ADDR_CMPB = 6'h10; // compare_value_b
  localparam logic [5:0] ADDR_TOP = 6'h14; // top_compare_value
  localparam logic [5:0] ADDR_FLAG = 6'h18; // timer_flag_register
  localparam logic [5:0] ADDR_PLL = 6'h1C; // pll_control_status_reg
  localparam logic [5:0] ADDR_MASK = 6'h20; // timer_interrupt_mask

  // field positions
  localparam int unsigned TCTL_CTC_BIT = 7;
  localparam int unsigned TCTL_PWM_BIT = 6;
  localparam int unsigned TCTL_MODE_LSB = 4;
  localparam int unsigned TCTL_PSEL_LSB = 0;
  localparam int unsigned GTC_MODEB_LSB = 4;
  localparam int unsigned GTC_PSR_BIT = 1;
  localparam int unsigned FLAG_A_BIT = 2;
  localparam int unsigned FLAG_B_BIT = 1;
  localparam int unsigned FLAG_OVF_BIT = 0;
  localparam int unsigned PLL_ACE_BIT = 2;
  localparam int unsigned PLL_LOCK_BIT = 0;

  // reset values
  localparam logic [7:0] RST_TCTL = 8'h00;
  localparam logic [1:0] RST_MODEB = 2'h0;
  localparam logic [7:0] RST_CMP = 8'h00;
  localparam logic [7:0] RST_TOP = 8'h00;
  localparam logic [2:0] RST_FLAGS = 3'h0;
  localparam logic [7:0] CNT_MAX = 8'hFF;

  // prescaler width: divide by up to 2**14 = 16384
  localparam int unsigned PSC_W = 14;

  // per-channel output mode
  typedef enum logic [1:0] {
    FTD_OUT_OFF,
    FTD_OUT_CLR_SET,
    FTD_OUT_CLR_ONLY,
    FTD_OUT_SET_CLR
  } ftd_outmode_e;

  // control word carried through the input synchronisation stages
  typedef struct packed {
    logic ctc;
    logic pwm;
    logic [1:0] mode_a;
    logic [3:0] psel;
    logic [1:0] mode_b;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [7:0] top;
    logic async_en;
  } ftd_ctl_s;

endpackage

// file: src/ftd_psc_if.sv
// link between the timer core and its prescaler
// assumes both ends run on the one system clock
interface ftd_psc_if;
  logic base_tick;
  logic clear;
  logic [3:0] select;
  logic tick;
  modport ctl (output base_tick, output clear, output select, input tick);
  modport psc (input base_tick, input clear, input select, output tick);
endinterface

// file: src/ftd_prescaler.sv
// prescaler: stop, or divide base ticks by 1, 2, 4 .. 16384
// assumes base ticks are one-cycle enables on the system clock
module ftd_prescaler
  import ftd_pkg::*;
#(
  parameter int unsigned DIV_W = PSC_W
) (
  input wire logic i_clk_sys, // system clock
  input wire logic i_reset, // synchronous reset, high
  ftd_psc_if.psc p // select, clear and tick
);

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] mask;

  // low bits that must all be one for a divided tick
  function automatic logic [DIV_W-1:0] div_mask(input logic [3:0] sel);
    logic [DIV_W-1:0] m;
    m = '0;
    if (sel != 4'h0) begin
      m = DIV_W'((32'h0000_0001 << (sel - 4'h1)) - 32'h0000_0001);
    end
    return m;
  endfunction

  assign mask = div_mask(p.select);

  // free divider, cleared by the prescaler reset strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || p.clear) begin // R3
      div_q <= '0;
    end else if (p.select != 4'h0 && p.base_tick) begin
      div_q <= div_q + 1'b1;
    end
  end

  // divided tick, none while stopped
  assign p.tick = (p.select != 4'h0) && p.base_tick && !p.clear // R2 R24
    && ((div_q & mask) == mask);

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  psc_stopped_a: assert property ((p.select == 4'h0) |-> !p.tick) // R24
    else $error("prescaler ticks while stopped");
  psc_undivided_a: assert property ( // R2
    (p.select == 4'h1 && p.base_tick && !p.clear) |-> p.tick)
    else $error("undivided setting missed a base tick");

endmodule // ftd_prescaler

// file: testbench/ftd_tb.sv
// self-checking bench for the fast dual pwm timer, top module tb
// assumes ftd_pkg and ftd_timer compiled first; one 125 MHz clock
module tb
  import ftd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst, rd_s, wr_s, fast_peripheral_clock, pck_on, lock, waitreq;
  logic [5:0] addr;
  logic [31:0] wdata, rdata;
  logic [2:0] ack, irq;
  logic oa, oa_oe, oan, oan_oe, ob, ob_oe, obn, obn_oe;
  int bad_count, tests_run;

  ftd_timer ftd_timer_inst (
    .i_clk_sys(clk), .i_reset(rst), .i_avs_address(addr),
    .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_pck_tick(fast_peripheral_clock), .i_pll_lock(lock), .i_irq_ack(ack), .o_irq_req(irq),
    .o_compare_output_a(oa), .o_compare_output_a_oe(oa_oe),
    .o_compare_output_a_n(oan), .o_compare_output_a_n_oe(oan_oe),
    .o_compare_output_b(ob), .o_compare_output_b_oe(ob_oe),
    .o_compare_output_b_n(obn), .o_compare_output_b_n_oe(obn_oe)
  );

  // 8 ns system clock
  always #4 clk = ~clk;

  // fast clock ticks: one pulse every second cycle while enabled
  always @(posedge clk) begin
    fast_peripheral_clock <= pck_on & ~fast_peripheral_clock;
  end

  // compare seen against expected and count the outcome
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    wr_s <= w;
    rd_s <= ~w;
    wdata <= 32'(d);
    @(posedge clk);
    // only the watchdog ends a wait that never gets an answer
    while (waitreq !== 1'b0) begin
      @(posedge clk);
    end
    q = rdata;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask

  task automatic wrr(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input string what, input logic [5:0] a,
                     input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(what, q, 32'(e));
  endtask

  // watch one channel for 80 cycles: high count, rising edges, pair errors
  task automatic sample(input bit chb, output int hi, output int rises,
                        output int bad_n);
    logic prev, cur;
    hi = 0;
    rises = 0;
    bad_n = 0;
    @(negedge clk);
    prev = chb ? ob : oa;
    repeat (80) begin
      @(negedge clk);
      cur = chb ? ob : oa;
      if (cur === 1'b1) hi++;
      if (cur === 1'b1 && prev === 1'b0) rises++;
      if ((chb ? obn : oan) !== ~cur) bad_n++;
      prev = cur;
    end
  endtask

  // sample and judge high time and edge count
  task automatic pwm_chk(input bit chb, input int e_hi, input int e_r);
    int hi, r, bn;
    sample(chb, hi, r, bn);
    chk("high cycles", hi, e_hi);
    chk("rising edges", r, e_r);
    chk("pair complement", bn, 0);
  endtask

  // reset state and read back of every control register except the pll register
  task automatic t_regs();
    logic [5:0] ad [6];
    logic [7:0] v [6];
    ad = '{ADDR_TCTL, ADDR_GTC, ADDR_CMPA, ADDR_CMPB, ADDR_TOP, ADDR_MASK};
    v = '{8'hB0, 8'h30, 8'hA5, 8'h5A, 8'hC3, 8'h07};
    chk("oe after reset", 32'({oa_oe, oan_oe, ob_oe, obn_oe}), 0);
    chk("irq after reset", 32'(irq), 0);
    for (int i = 0; i < 6; i++) begin
      rdc("reset value", ad[i], 8'h00);
      wrr(ad[i], v[i]);
      rdc("read back", ad[i], v[i]);
      wrr(ad[i], 8'h00);
    end
    wrr(6'h24, 8'h77);
    rdc("unmapped", 6'h24, 8'h00);
    wrr(ADDR_CNT, 8'h55);
    rdc("count write ignored", ADDR_CNT, 8'h00);
    wrr(ADDR_GTC, 8'h32);
    rdc("prescaler reset strobe", ADDR_GTC, 8'h30);
  endtask

  // normal mode: wrap overflow, compare flags, clearing, stop
  task automatic t_normal();
    logic [31:0] q1, q2;
    wrr(ADDR_TOP, 8'h14);
    wrr(ADDR_CMPA, 8'h03);
    wrr(ADDR_CMPB, 8'h05);
    wrr(ADDR_GTC, 8'h10);
    wrr(ADDR_MASK, 8'h07);
    wrr(ADDR_FLAG, 8'h07);
    wrr(ADDR_TCTL, 8'h11);
    repeat (300) @(posedge clk);
    rdc("flags after wrap", ADDR_FLAG, 8'h07);
    chk("irq request", 32'(irq), 7);
    chk("normal oe", 32'({oa_oe, oan_oe, ob_oe, obn_oe}), 32'hA);
    wrr(ADDR_FLAG, 8'h00);
    rdc("write zero keeps", ADDR_FLAG, 8'h07);
    wrr(ADDR_TCTL, 8'h10);
    repeat (5) @(posedge clk);
    bus(1'b0, ADDR_CNT, 8'h00, q1);
    wrr(ADDR_FLAG, 8'h06);
    rdc("write one clears", ADDR_FLAG, 8'h01);
    @(posedge clk);
    ack <= 3'b001;
    @(posedge clk);
    ack <= 3'b000;
    repeat (40) @(posedge clk);
    rdc("serviced clears", ADDR_FLAG, 8'h00);
    chk("irq cleared", 32'(irq), 0);
    bus(1'b0, ADDR_CNT, 8'h00, q2);
    chk("stopped count", q2, q1);
  endtask

  // clear on top keeps the count within top
  task automatic t_ctc();
    logic [31:0] q;
    wrr(ADDR_TCTL, 8'h81);
    // count may start above top and must wrap through ff once first
    repeat (300) @(posedge clk);
    repeat (30) begin
      bus(1'b0, ADDR_CNT, 8'h00, q);
      chk("count within top", 32'(q > 32'h0000_0014), 0);
    end
    wrr(ADDR_TCTL, 8'h00);
  endtask

  // pwm output modes, buffering, prescaler ratios, constant levels
  task automatic t_pwm();
    logic [7:0] tc [4];
    logic [7:0] cv [4];
    int eh [4];
    tc = '{8'h51, 8'h51, 8'h71, 8'h71};
    cv = '{8'h00, 8'h09, 8'h00, 8'h09};
    eh = '{0, 80, 80, 0};
    wrr(ADDR_TOP, 8'h09);
    wrr(ADDR_CMPA, 8'h03);
    wrr(ADDR_CMPB, 8'h05);
    wrr(ADDR_GTC, 8'h30);
    wrr(ADDR_TCTL, 8'h51);
    // a count left above top runs on to ff before pwm settles
    repeat (300) @(posedge clk);
    pwm_chk(1'b0, 24, 8);
    pwm_chk(1'b1, 40, 8);
    chk("pwm oe", 32'({oa_oe, oan_oe, ob_oe, obn_oe}), 32'hE);
    wrr(ADDR_FLAG, 8'h07);
    repeat (30) @(posedge clk);
    rdc("pwm flags", ADDR_FLAG, 8'h07);
    wrr(ADDR_TCTL, 8'h61);
    // two sync stages and the enable flop before the pins change
    repeat (4) @(posedge clk);
    chk("mode 10 inverted", 32'({oa_oe, oan_oe}), 2);
    pwm_chk(1'b0, 24, 8);
    wrr(ADDR_TCTL, 8'h41);
    repeat (4) @(posedge clk);
    chk("mode 00 oe", 32'({oa_oe, oan_oe}), 0);
    wrr(ADDR_TCTL, 8'h51);
    wrr(ADDR_CMPA, 8'h06);
    rdc("buffered read", ADDR_CMPA, 8'h06);
    repeat (30) @(posedge clk);
    pwm_chk(1'b0, 48, 8);
    for (int p = 1; p <= 4; p++) begin
      wrr(ADDR_TCTL, 8'h50 | 8'(p));
      repeat (100) @(posedge clk);
      pwm_chk(1'b0, 48, 8 >> (p - 1));
    end
    for (int i = 0; i < 4; i++) begin
      wrr(ADDR_TCTL, tc[i]);
      wrr(ADDR_CMPA, cv[i]);
      repeat (40) @(posedge clk);
      pwm_chk(1'b0, eh[i], 0);
    end
    wrr(ADDR_CMPA, 8'h03);
  endtask

  // async start: pll wait, lock poll, then fast clock base
  task automatic t_async();
    logic [31:0] q, q1;
    int n;
    n = 0;
    wrr(ADDR_TCTL, 8'h51);
    repeat (200) @(posedge clk);
    lock <= 1'b1;
    repeat (12500) @(posedge clk);
    q = 0;
    while (q[0] !== 1'b1 && n < 20) begin
      bus(1'b0, ADDR_PLL, 8'h00, q);
      n++;
    end
    chk("pll lock seen", 32'(q[0]), 1);
    wrr(ADDR_PLL, 8'h04);
    rdc("pll register", ADDR_PLL, 8'h05);
    pck_on <= 1'b1;
    repeat (60) @(posedge clk);
    pwm_chk(1'b0, 24, 4);
    pck_on <= 1'b0;
    repeat (10) @(posedge clk);
    bus(1'b0, ADDR_CNT, 8'h00, q1);
    repeat (30) @(posedge clk);
    bus(1'b0, ADDR_CNT, 8'h00, q);
    chk("no fast ticks", q, q1);
  endtask

  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    results();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {rd_s, wr_s, pck_on, lock} = '0;
    addr = '0;
    wdata = '0;
    ack = '0;
    bad_count = 0;
    tests_run = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_normal();
    t_ctc();
    t_pwm();
    t_async();
    results();
  end
endmodule // tb
